// >>> logic/ums_modem_status.sv
// uart modem status logic: modem status, receive-ready flag, auto cts halt
// assumes the uart core supplies the receive count and transmitter busy level
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
module ums_modem_status #(
  parameter int RXCNT_W = 5
) (
  // clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // axi4-lite slave
  input  wire logic [ums_pkg::AXI_AW-1:0]  awaddr,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [ums_pkg::AXI_DW-1:0]  wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  input  wire logic [ums_pkg::AXI_AW-1:0]  araddr,
  input  wire logic                        arvalid,
  output logic                             arready,
  output logic [ums_pkg::AXI_DW-1:0]       rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  // modem pins, active low
  input  wire ums_pkg::ums_modem_s         modem_pins_n,
  output logic                             dtr_n,
  output logic                             rts_n,
  output logic                             user_output_one_n,
  output logic                             user_output_two_n,
  // uart core side
  input  wire logic [RXCNT_W-1:0]          rx_count,
  input  wire logic                        tx_busy,
  output logic                             tx_halt,
  // interrupts
  output logic                             modem_irq,
  output logic                             irq
);
  logic                             wr_en;
  ums_pkg::ums_wr_s                 wr_req;
  logic                             wr_ok;
  logic                             rd_en;
  logic [ums_pkg::AXI_AW-1:0]       rd_addr;
  logic [ums_pkg::AXI_DW-1:0]       rd_data;
  logic                             rd_ok;
  logic [ums_pkg::ML_N-1:0]         pins_sync_n;
  logic [ums_pkg::ML_N-1:0]         stat_now;
  logic [ums_pkg::ML_N-1:0]         chg;
  logic                             ms_rd;
  logic                             wr_lane;
  logic                             rx_any;

  logic [ums_pkg::MCR_W-1:0]        mcr_ff,      nxt_mcr;
  logic                             auto_cts_ff, nxt_auto_cts;
  logic [ums_pkg::IRQ_N-1:0]        ien_ff,      nxt_ien;
  logic [ums_pkg::IRQ_N-1:0]        ists_ff,     nxt_ists;
  logic [ums_pkg::ML_N-1:0]         prev_ff,     nxt_prev;
  logic [ums_pkg::ML_N-1:0]         delta_ff,    nxt_delta;
  logic                             rx_ready_ff, nxt_rx_ready;
  logic                             tx_halt_ff,  nxt_tx_halt;

  ums_axil_slave u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr_en   (wr_en),
    .wr_req  (wr_req),
    .wr_ok   (wr_ok),
    .rd_en   (rd_en),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  // modem inputs into the clock domain
  ums_modem_sync #(
    .W (ums_pkg::ML_N)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_n   (modem_pins_n),
    .sync_n  (pins_sync_n)
  );

  // status levels: complemented pins, or modem_control bits in loop-back
  always_comb begin
    if (mcr_ff[ums_pkg::MCR_LOOP]) begin
      stat_now[ums_pkg::ML_DCD] = mcr_ff[ums_pkg::MCR_USER_OUTPUT_TWO];
      stat_now[ums_pkg::ML_RI]  = mcr_ff[ums_pkg::MCR_USER_OUTPUT_ONE];
      stat_now[ums_pkg::ML_DSR] = mcr_ff[ums_pkg::MCR_DTR];
      stat_now[ums_pkg::ML_CTS] = mcr_ff[ums_pkg::MCR_RTS];
    end else begin
      stat_now = ~pins_sync_n;
    end
  end

  // change detection against the previous sample
  always_comb begin
    chg = stat_now ^ prev_ff;
    chg[ums_pkg::ML_RI] = prev_ff[ums_pkg::ML_RI] && !stat_now[ums_pkg::ML_RI];
    nxt_prev = stat_now;
  end

  // register access decode
  always_comb begin
    ms_rd   = rd_en && (rd_addr == ums_pkg::OFS_MODEM_STATUS);
    wr_lane = wr_en && wr_req.strb[0];
    rd_ok   = 1'b1;
    rd_data = '0;
    case (rd_addr)
      ums_pkg::OFS_LINE_STATUS:  rd_data[ums_pkg::LS_RX_READY] = rx_ready_ff;
      ums_pkg::OFS_MODEM_STATUS: rd_data[ums_pkg::REG_W-1:0] = {stat_now, delta_ff};
      ums_pkg::OFS_MODEM_CTRL:   rd_data[ums_pkg::MCR_W-1:0] = mcr_ff;
      ums_pkg::OFS_ENH_FEATURE:  rd_data[ums_pkg::EFR_AUTO_CTS] = auto_cts_ff;
      ums_pkg::OFS_IRQ_STATUS:   rd_data[ums_pkg::IRQ_N-1:0] = ists_ff;
      ums_pkg::OFS_IRQ_CLEAR:    rd_data = '0;
      ums_pkg::OFS_IRQ_ENABLE:   rd_data[ums_pkg::IRQ_N-1:0] = ien_ff;
      default:                   rd_ok = 1'b0;
    endcase
    case (wr_req.addr)
      ums_pkg::OFS_LINE_STATUS,
      ums_pkg::OFS_MODEM_STATUS,
      ums_pkg::OFS_MODEM_CTRL,
      ums_pkg::OFS_ENH_FEATURE,
      ums_pkg::OFS_IRQ_STATUS,
      ums_pkg::OFS_IRQ_CLEAR,
      ums_pkg::OFS_IRQ_ENABLE:   wr_ok = 1'b1;
      default:                   wr_ok = 1'b0;
    endcase
  end

  // software writable control
  always_comb begin
    nxt_mcr      = mcr_ff;
    nxt_auto_cts = auto_cts_ff;
    nxt_ien      = ien_ff;
    if (wr_lane && wr_req.addr == ums_pkg::OFS_MODEM_CTRL) begin
      nxt_mcr = wr_req.data[ums_pkg::MCR_W-1:0];
    end
    if (wr_lane && wr_req.addr == ums_pkg::OFS_ENH_FEATURE) begin
      nxt_auto_cts = wr_req.data[ums_pkg::EFR_AUTO_CTS];
    end
    if (wr_lane && wr_req.addr == ums_pkg::OFS_IRQ_ENABLE) begin
      nxt_ien = wr_req.data[ums_pkg::IRQ_N-1:0];
    end
  end

  // change bits: a change in the read cycle survives the clear
  always_comb begin
    nxt_delta = delta_ff;
    if (ms_rd) begin
      nxt_delta = ums_pkg::DELTA_RST;
    end
    nxt_delta = nxt_delta | chg;
  end

  // receive ready, sticky interrupt status, transmit halt
  always_comb begin
    rx_any       = (rx_count != '0);
    nxt_rx_ready = rx_any;
    nxt_ists     = ists_ff;
    if (wr_lane && wr_req.addr == ums_pkg::OFS_IRQ_CLEAR) begin
      nxt_ists = ists_ff & ~wr_req.data[ums_pkg::IRQ_N-1:0];
    end
    nxt_ists[ums_pkg::IRQ_MODEM] = nxt_ists[ums_pkg::IRQ_MODEM] | (|chg);
    nxt_ists[ums_pkg::IRQ_RX]    = nxt_ists[ums_pkg::IRQ_RX] | (rx_any && !rx_ready_ff);
    nxt_tx_halt = tx_halt_ff;
    if (!tx_busy) begin
      nxt_tx_halt = auto_cts_ff && pins_sync_n[ums_pkg::ML_CTS];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mcr_ff      <= ums_pkg::MCR_RST;
      auto_cts_ff <= ums_pkg::EFR_RST;
      ien_ff      <= ums_pkg::IRQ_RST;
      ists_ff     <= ums_pkg::IRQ_RST;
      prev_ff     <= ums_pkg::STAT_RST;
      delta_ff    <= ums_pkg::DELTA_RST;
      rx_ready_ff <= 1'b0;
      tx_halt_ff  <= 1'b0;
    end else begin
      mcr_ff      <= nxt_mcr;
      auto_cts_ff <= nxt_auto_cts;
      ien_ff      <= nxt_ien;
      ists_ff     <= nxt_ists;
      prev_ff     <= nxt_prev;
      delta_ff    <= nxt_delta;
      rx_ready_ff <= nxt_rx_ready;
      tx_halt_ff  <= nxt_tx_halt;
    end
  end

  // outputs; modem outputs sit inactive in loop-back
  assign dtr_n             = !(mcr_ff[ums_pkg::MCR_DTR]  && !mcr_ff[ums_pkg::MCR_LOOP]);
  assign rts_n             = !(mcr_ff[ums_pkg::MCR_RTS]  && !mcr_ff[ums_pkg::MCR_LOOP]);
  assign user_output_one_n = !(mcr_ff[ums_pkg::MCR_USER_OUTPUT_ONE] && !mcr_ff[ums_pkg::MCR_LOOP]);
  assign user_output_two_n = !(mcr_ff[ums_pkg::MCR_USER_OUTPUT_TWO] && !mcr_ff[ums_pkg::MCR_LOOP]);
  assign tx_halt           = tx_halt_ff;
  assign modem_irq         = |delta_ff;
  assign irq               = |(ists_ff & ien_ff);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_rx_ready_follow: assert property (
    ##1 rx_ready_ff == $past(rx_any))
    else $error("receive ready does not follow held count");
  chk_delta_latch: assert property (
    chg != '0 |=> (delta_ff & $past(chg)) == $past(chg))
    else $error("change bit not latched");
  chk_read_clear: assert property (
    ms_rd && chg == '0 |=> delta_ff == '0)
    else $error("change bits not cleared by read");
  chk_dcd_mirror: assert property (
    ms_rd |=> rdata[ums_pkg::ML_N + ums_pkg::ML_DCD] == $past(mcr_ff[ums_pkg::MCR_LOOP] ?
      mcr_ff[ums_pkg::MCR_USER_OUTPUT_TWO] : !pins_sync_n[ums_pkg::ML_DCD]))
    else $error("carrier status bit wrong");
  chk_ri_mirror: assert property (
    ms_rd && mcr_ff[ums_pkg::MCR_LOOP] |=>
      rdata[ums_pkg::ML_N + ums_pkg::ML_RI] == $past(mcr_ff[ums_pkg::MCR_USER_OUTPUT_ONE]))
    else $error("ring status bit wrong in loop-back");
  chk_dsr_mirror: assert property (
    ms_rd && !mcr_ff[ums_pkg::MCR_LOOP] |=>
      rdata[ums_pkg::ML_N + ums_pkg::ML_DSR] != $past(pins_sync_n[ums_pkg::ML_DSR]))
    else $error("dsr status bit not inverted pin");
  chk_cts_mirror: assert property (
    ms_rd && mcr_ff[ums_pkg::MCR_LOOP] |=>
      rdata[ums_pkg::ML_N + ums_pkg::ML_CTS] == $past(mcr_ff[ums_pkg::MCR_RTS]))
    else $error("cts status bit wrong in loop-back");
  chk_halt_boundary: assert property (
    tx_busy && !tx_halt_ff |=> !tx_halt_ff)
    else $error("transmit halted mid character");
  chk_halt_on_cts: assert property (
    !tx_busy && auto_cts_ff && pins_sync_n[ums_pkg::ML_CTS] |=> tx_halt_ff)
    else $error("auto cts failed to halt");
  chk_dcd_irq: assert property (
    stat_now[ums_pkg::ML_DCD] != prev_ff[ums_pkg::ML_DCD] |=> delta_ff[ums_pkg::ML_DCD] && modem_irq)
    else $error("carrier change not flagged");
  chk_ri_edge_only: assert property (
    !chg[ums_pkg::ML_RI] && !delta_ff[ums_pkg::ML_RI] |=> !delta_ff[ums_pkg::ML_RI])
    else $error("ring change bit set without falling status");
  chk_irq_pending: assert property (
    delta_ff != '0 && !ms_rd |=> modem_irq)
    else $error("modem interrupt dropped without read");
endmodule : ums_modem_status

// >>> inc/ums_pkg.sv
// package for the uart modem status logic: offsets, bit positions, resets
// assumes a 32-bit axi4-lite register bus and 8-bit registers in the low byte
package ums_pkg;
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;
  localparam int REG_W  = 8;
  // register byte offsets
  localparam logic [AXI_AW-1:0] OFS_LINE_STATUS  = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_MODEM_STATUS = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_MODEM_CTRL   = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_ENH_FEATURE  = 8'h0C;
  localparam logic [AXI_AW-1:0] OFS_IRQ_STATUS   = 8'h10;
  localparam logic [AXI_AW-1:0] OFS_IRQ_CLEAR    = 8'h14;
  localparam logic [AXI_AW-1:0] OFS_IRQ_ENABLE   = 8'h18;
  // modem_control fields
  localparam int MCR_DTR  = 0;
  localparam int MCR_RTS  = 1;
  localparam int MCR_USER_OUTPUT_ONE = 2;
  localparam int MCR_USER_OUTPUT_TWO = 3;
  localparam int MCR_LOOP = 4;
  localparam int MCR_W    = 5;
  // enhanced_feature_control field
  localparam int EFR_AUTO_CTS = 7;
  // modem status line indices inside the 4-bit vectors (dcd, ri, dsr, cts)
  localparam int ML_DCD = 3;
  localparam int ML_RI  = 2;
  localparam int ML_DSR = 1;
  localparam int ML_CTS = 0;
  localparam int ML_N   = 4;
  // line_status field
  localparam int LS_RX_READY = 0;
  // interrupt status fields
  localparam int IRQ_MODEM = 0;
  localparam int IRQ_RX    = 1;
  localparam int IRQ_N     = 2;
  // reset values
  localparam logic [MCR_W-1:0] MCR_RST  = 5'h00;
  localparam logic             EFR_RST  = 1'b0;
  localparam logic [IRQ_N-1:0] IRQ_RST  = 2'h0;
  localparam logic [ML_N-1:0]  DELTA_RST = 4'h0;
  localparam logic [ML_N-1:0]  STAT_RST  = 4'h0;
  localparam logic [ML_N-1:0]  PIN_IDLE  = 4'hF;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } ums_modem_s;

  typedef struct packed {
    logic [AXI_AW-1:0] addr;
    logic [AXI_DW-1:0] data;
    logic [3:0]        strb;
  } ums_wr_s;
endpackage : ums_pkg

// >>> logic/ums_modem_sync.sv
// two-flop synchroniser for the active-low modem input pins
// assumes the pins idle high; reset loads the idle level
`timescale 1ns/100ps
module ums_modem_sync #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // pins and synchronised levels
  input  wire logic [W-1:0] pin_n,
  output logic      [W-1:0] sync_n
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta_ff[g] <= ums_pkg::PIN_IDLE[g];
          sync_ff[g] <= ums_pkg::PIN_IDLE[g];
        end else begin
          meta_ff[g] <= pin_n[g];
          sync_ff[g] <= meta_ff[g];
        end
      end
    end
  endgenerate

  assign sync_n = sync_ff;
endmodule : ums_modem_sync

// >>> logic/ums_axil_slave.sv
// axi4-lite slave: turns bus transfers into register read and write strobes
// assumes the register file decodes combinationally and answers in the same cycle
`timescale 1ns/100ps
module ums_axil_slave (
  // clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // write address and data
  input  wire logic [ums_pkg::AXI_AW-1:0]  awaddr,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [ums_pkg::AXI_DW-1:0]  wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  // write response
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  // read address and data
  input  wire logic [ums_pkg::AXI_AW-1:0]  araddr,
  input  wire logic                        arvalid,
  output logic                             arready,
  output logic [ums_pkg::AXI_DW-1:0]       rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  // register side
  output logic                             wr_en,
  output ums_pkg::ums_wr_s                 wr_req,
  input  wire logic                        wr_ok,
  output logic                             rd_en,
  output logic [ums_pkg::AXI_AW-1:0]       rd_addr,
  input  wire logic [ums_pkg::AXI_DW-1:0]  rd_data,
  input  wire logic                        rd_ok
);
  logic                        aw_held_ff, nxt_aw_held;
  logic                        w_held_ff,  nxt_w_held;
  ums_pkg::ums_wr_s            req_ff,     nxt_req;
  logic                        bvalid_ff,  nxt_bvalid;
  logic [1:0]                  bresp_ff,   nxt_bresp;
  logic                        rvalid_ff,  nxt_rvalid;
  logic [1:0]                  rresp_ff,   nxt_rresp;
  logic [ums_pkg::AXI_DW-1:0]  rdata_ff,   nxt_rdata;

  // write channel: address and data in either order, then one response
  always_comb begin
    awready     = !aw_held_ff && !bvalid_ff;
    wready      = !w_held_ff && !bvalid_ff;
    wr_en       = aw_held_ff && w_held_ff;
    nxt_aw_held = aw_held_ff;
    nxt_w_held  = w_held_ff;
    nxt_req     = req_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    if (awvalid && awready) begin
      nxt_aw_held  = 1'b1;
      nxt_req.addr = awaddr;
    end
    if (wvalid && wready) begin
      nxt_w_held   = 1'b1;
      nxt_req.data = wdata;
      nxt_req.strb = wstrb;
    end
    if (wr_en) begin
      nxt_aw_held = 1'b0;
      nxt_w_held  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = wr_ok ? ums_pkg::RESP_OKAY : ums_pkg::RESP_SLVERR;
    end
    if (bvalid_ff && bready) begin
      nxt_bvalid = 1'b0;
    end
  end

  // read channel: data one cycle after the address is taken
  always_comb begin
    arready    = !rvalid_ff;
    rd_en      = arvalid && arready;
    rd_addr    = araddr;
    nxt_rvalid = rvalid_ff;
    nxt_rresp  = rresp_ff;
    nxt_rdata  = rdata_ff;
    if (rd_en) begin
      nxt_rvalid = 1'b1;
      nxt_rdata  = rd_data;
      nxt_rresp  = rd_ok ? ums_pkg::RESP_OKAY : ums_pkg::RESP_SLVERR;
    end else if (rvalid_ff && rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      req_ff     <= '0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= ums_pkg::RESP_OKAY;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= ums_pkg::RESP_OKAY;
      rdata_ff   <= '0;
    end else begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff  <= nxt_w_held;
      req_ff     <= nxt_req;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      rvalid_ff  <= nxt_rvalid;
      rresp_ff   <= nxt_rresp;
      rdata_ff   <= nxt_rdata;
    end
  end

  assign wr_req = req_ff;
  assign bvalid = bvalid_ff;
  assign bresp  = bresp_ff;
  assign rvalid = rvalid_ff;
  assign rresp  = rresp_ff;
  assign rdata  = rdata_ff;
endmodule : ums_axil_slave

// >>> testbench/ums_modem_model.sv
// modem partner: drives the active-low modem pins at the levels the bench requests
// assumes pins idle high while reset is held
`timescale 1ns/100ps
module ums_modem_model (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // requested pin levels and pins
  input  wire logic [3:0]   lvl,
  output ums_pkg::ums_modem_s pins_n
);
  // levels move just after a clock edge, as a real modem is unrelated to the bus
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_n <= ums_pkg::PIN_IDLE;
    end else begin
      pins_n <= lvl;
    end
  end
endmodule : ums_modem_model

// >>> testbench/tb_top.sv
// self-checking bench for the modem status logic, with an integer model
// assumes the dut answers axi4-lite transfers within 40 cycles
`timescale 1ns/100ps
module tb_top;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, arready, bvalid, rvalid, tx_busy, tx_halt;
  logic        dtr_n, rts_n, user_output_one_n, user_output_two_n, modem_irq, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb, lvl, mv;
  logic [1:0]  bresp, rresp, r;
  logic [4:0]  rx_count;
  ums_pkg::ums_modem_s modem_pins_n;
  int          miscompares, num_checks, seed, st, dl, i, v, pv;

  ums_modem_status dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .modem_pins_n, .dtr_n, .rts_n, .user_output_one_n,
    .user_output_two_n, .rx_count, .tx_busy, .tx_halt, .modem_irq, .irq);
  ums_modem_model modem (.aclk, .aresetn, .lvl, .pins_n(modem_pins_n));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask : wt

  task automatic axw(input logic [7:0] a, input logic [31:0] x);
    int n;
    awaddr <= a;
    wdata <= x;
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        break;
      end
    end
    bready <= 1'b0;
    if (n == 40) begin
      miscompares++;
      results();
    end
    @(posedge aclk);
  endtask : axw

  task automatic axr(input logic [7:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        break;
      end
    end
    rready <= 1'b0;
    if (n == 40) begin
      miscompares++;
      results();
    end
    @(posedge aclk);
  endtask : axr

  // change bits: any edge for carrier, dsr, cts; ring only when its status falls
  function automatic void apply(input int ns);
    dl = dl | ((st ^ ns) & 'hB) | (st & ~ns & 'h4);
    st = ns;
  endfunction : apply

  task automatic setp(input int x);
    pv = x & 15;
    lvl <= pv[3:0];
    apply(~pv & 15);
    wt(6);
  endtask : setp

  task automatic rdms;
    chk(modem_irq, dl != 0);
    axr(ums_pkg::OFS_MODEM_STATUS);
    chk(d, (st << 4) | dl);
    dl = 0;
  endtask : rdms

  initial begin
    seed = 97011;
    miscompares = 0;
    num_checks = 0;
    st = 0;
    dl = 0;
    pv = 15;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, tx_busy} = '0;
    {awaddr, araddr, wdata, wstrb, rx_count} = '0;
    lvl = 4'hF;
    wt(10);
    aresetn <= 1'b1;
    wt(2);
    axr(ums_pkg::OFS_LINE_STATUS);
    chk(d, 0);
    rdms();
    axr(8'h40);
    chk(r, ums_pkg::RESP_SLVERR);
    axw(8'h40, 1);
    chk(r, ums_pkg::RESP_SLVERR);
    axw(ums_pkg::OFS_IRQ_ENABLE, 0);
    chk(r, ums_pkg::RESP_OKAY);
    rx_count <= 5'(($random(seed) & 30) | 1);
    wt(3);
    axr(ums_pkg::OFS_LINE_STATUS);
    chk(d, 1);
    rx_count <= 5'h00;
    wt(3);
    axr(ums_pkg::OFS_LINE_STATUS);
    chk(d, 0);
    for (i = 0; i < 12; i++) begin
      v = (i < 8) ? pv ^ (1 << (i % 4)) : $random(seed);
      setp(v);
      rdms();
      rdms();
    end
    v = $random(seed) & 15;
    axw(ums_pkg::OFS_MODEM_CTRL, v);
    chk({user_output_two_n, user_output_one_n, rts_n, dtr_n}, ~v & 15);
    for (i = 0; i < 4; i++) begin
      v = ($random(seed) & 15) | 16;
      axw(ums_pkg::OFS_MODEM_CTRL, v);
      mv = {v[3], v[2], v[0], v[1]};
      apply(mv);
      wt(6);
      chk({user_output_two_n, user_output_one_n, rts_n, dtr_n}, 15);
      rdms();
    end
    axw(ums_pkg::OFS_MODEM_CTRL, 0);
    apply(~pv & 15);
    wt(6);
    rdms();
    setp(pv & 14);
    tx_busy <= 1'b1;
    axw(ums_pkg::OFS_ENH_FEATURE, 32'h0000_0080);
    wt(3);
    chk(tx_halt, 0);
    setp(pv | 1);
    chk(tx_halt, 0);
    tx_busy <= 1'b0;
    wt(3);
    chk(tx_halt, 1);
    tx_busy <= 1'b1;
    setp(pv & 14);
    chk(tx_halt, 1);
    tx_busy <= 1'b0;
    wt(3);
    chk(tx_halt, 0);
    rdms();
    axw(ums_pkg::OFS_IRQ_CLEAR, 3);
    axr(ums_pkg::OFS_IRQ_STATUS);
    chk(d, 0);
    axw(ums_pkg::OFS_IRQ_ENABLE, 1);
    setp(pv ^ 8);
    axr(ums_pkg::OFS_IRQ_STATUS);
    chk(d, 1);
    chk(irq, 1);
    axw(ums_pkg::OFS_IRQ_ENABLE, 0);
    chk(irq, 0);
    rdms();
    rx_count <= 5'h07;
    wt(3);
    axr(ums_pkg::OFS_IRQ_STATUS);
    chk(d, 3);
    axw(ums_pkg::OFS_IRQ_ENABLE, 2);
    chk(irq, 1);
    axw(ums_pkg::OFS_IRQ_CLEAR, 3);
    axr(ums_pkg::OFS_IRQ_STATUS);
    chk(d, 0);
    chk(irq, 0);
    axr(ums_pkg::OFS_IRQ_CLEAR);
    chk(d, 0);
    axr(ums_pkg::OFS_IRQ_ENABLE);
    chk(d, 2);
    results();
  end
endmodule : tb_top
